// ### design/dlms_seq.sv
// Lane mode sequencer: transmit line-state order and receive settle windows
`timescale 1ns/10ps
// What this block does
// - The lane alternates between low-power signalling and high-speed bursts on both ends.
// - Transmit entry into high speed walks LP-11, LP-01, LP-00 in that order.
// - Transmit leaves high speed by returning the lane to LP-11.
// - The high-speed clock runs at least 8 UI before the data lane starts its entry.
// - The clock lane holds LP-00 for 38 to 95 ns just before its HS-0.
// - The receiver ignores clock-lane high-speed activity for the settle time after LP-00.
// - The clock lane drives HS-0 at least 60 ns after the last clock bit.
// - Clock prepare plus clock zero totals at least 300 ns.
// - The data lane holds LP-00 between 40 ns plus 4 UI and 85 ns plus 6 UI.
// - The receiver ignores data-lane activity for the data settle time after LP-00.
// - The data trail lasts at least max(n*8 UI, 60 ns plus n*4 UI).
// - Every transmitted LP-11 and LP-01 state lasts at least 50 ns.
// - Data prepare plus data zero totals at least 145 ns plus 10 UI.
// - The clock keeps running from the end of data trail to the start of clock trail.
// - Clock and data settle times are set between 40 and 2590 ns.
module dlms_seq (
  input  wire logic                       clk_sys_i,
  input  wire logic                       nrst_i,
  input  wire logic                       clk_cal_i,
  input  wire logic                       tx_req_i,
  output logic [1:0]                      tx_clk_lp_o,
  output logic                            tx_clk_hs_oe_o,
  output logic                            tx_clk_run_o,
  output logic [1:0]                      tx_dat_lp_o,
  output logic                            tx_dat_hs_oe_o,
  output logic                            tx_dat_sync_o,
  output logic                            tx_dat_payload_o,
  output logic                            tx_dat_trail_o,
  output logic                            tx_busy_o,
  input  wire logic [1:0]                 rx_clk_lp_i,
  input  wire logic [1:0]                 rx_dat_lp_i,
  input  wire logic [dlms_pkg::SET_W-1:0] rx_clk_settle_ns_i,
  input  wire logic [dlms_pkg::SET_W-1:0] rx_hs_settle_ns_i,
  output logic                            rx_clk_hs_en_o,
  output logic                            rx_dat_hs_en_o,
  output logic                            rx_burst_o
);
  import dlms_pkg::*;

  // ****************************************************************
  // Reset release, one synchroniser per clock domain
  // ****************************************************************
  logic [1:0] rst_sys_q;
  logic [1:0] rst_cal_q;
  logic       rst_n;
  logic       rst_cal_n;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sys_q <= RST_SYNC_INIT;
    end else begin
      rst_sys_q <= {rst_sys_q[0], 1'b1};
    end
  end

  always_ff @(posedge clk_cal_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_cal_q <= RST_SYNC_INIT;
    end else begin
      rst_cal_q <= {rst_cal_q[0], 1'b1};
    end
  end

  assign rst_n     = rst_sys_q[1];
  assign rst_cal_n = rst_cal_q[1];

  // ****************************************************************
  // Transmit sequencer on the system clock
  // ****************************************************************
  dlms_tx_e         state_q;
  dlms_tx_e         state_d;
  logic [TMR_W-1:0] dur_q;
  logic [TMR_W-1:0] dur_d;
  logic [TMR_W-1:0] run_q;
  logic [TMR_W-1:0] run_d;
  logic [1:0]       clk_lp_d;
  logic [1:0]       dat_lp_d;
  logic             clk_oe_d;
  logic             run_en_d;
  logic             dat_oe_d;
  logic             sync_d;
  logic             pay_d;
  logic             trail_d;

  dlms_tmr_if tx_tmr ();

  dlms_timer u_tx_tmr (
    .clk_i   (clk_sys_i),
    .rst_n_i (rst_n),
    .tmr     (tx_tmr)
  );

  // Next state; each timed state leaves only when its counter expires
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      TX_IDLE:        if (tx_req_i) state_d = TX_CLK_LP01;
      TX_CLK_LP01:    if (tx_tmr.done) state_d = TX_CLK_LP00;
      TX_CLK_LP00:    if (tx_tmr.done) state_d = TX_CLK_ZERO;
      TX_CLK_ZERO:    if (tx_tmr.done) state_d = TX_CLK_PRE;
      TX_CLK_PRE:     if (tx_tmr.done) state_d = TX_DAT_LP01;
      TX_DAT_LP01:    if (tx_tmr.done) state_d = TX_DAT_LP00;
      TX_DAT_LP00:    if (tx_tmr.done) state_d = TX_DAT_ZERO;
      TX_DAT_ZERO:    if (tx_tmr.done) state_d = TX_DAT_SYNC;
      TX_DAT_SYNC:    if (tx_tmr.done) state_d = TX_DAT_PAYLOAD;
      TX_DAT_PAYLOAD: if (!tx_req_i) state_d = TX_DAT_TRAIL;
      TX_DAT_TRAIL:   if (tx_tmr.done) state_d = TX_CLK_POST;
      TX_CLK_POST:    if (tx_tmr.done) state_d = TX_CLK_TRAIL;
      TX_CLK_TRAIL:   if (tx_tmr.done) state_d = TX_CLK_STOP;
      TX_CLK_STOP:    if (tx_tmr.done) state_d = TX_IDLE;
      default:        state_d = TX_IDLE;
    endcase
  end

  // Interval for the state being entered, loaded on the entry edge
  always_comb begin
    tx_tmr.load  = (state_d != state_q);
    tx_tmr.value = ONE_CNT;
    unique case (state_d)
      TX_CLK_LP01, TX_DAT_LP01, TX_CLK_STOP: tx_tmr.value = LPX_CNT;
      TX_CLK_LP00:  tx_tmr.value = CLK_PREP_CNT;
      TX_CLK_ZERO:  tx_tmr.value = CLK_ZERO_CNT;
      TX_CLK_PRE:   tx_tmr.value = CLK_PRE_CNT;
      TX_DAT_LP00:  tx_tmr.value = HS_PREP_CNT;
      TX_DAT_ZERO:  tx_tmr.value = HS_ZERO_CNT;
      TX_DAT_TRAIL: tx_tmr.value = HS_TRAIL_CNT;
      TX_CLK_POST:  tx_tmr.value = CLK_POST_CNT;
      TX_CLK_TRAIL: tx_tmr.value = CLK_TRAIL_CNT;
      default:      tx_tmr.value = ONE_CNT;
    endcase
  end

  // Pin levels from the next state, so registered pins track the state
  always_comb begin
    clk_oe_d = state_d inside {[TX_CLK_ZERO:TX_CLK_TRAIL]};
    run_en_d = state_d inside {[TX_CLK_PRE:TX_CLK_POST]};
    dat_oe_d = state_d inside {[TX_DAT_ZERO:TX_DAT_TRAIL]};
    sync_d   = (state_d == TX_DAT_SYNC);
    pay_d    = (state_d == TX_DAT_PAYLOAD);
    trail_d  = (state_d == TX_DAT_TRAIL);
    clk_lp_d = LP11;
    dat_lp_d = LP11;
    if (state_d == TX_CLK_LP01) begin
      clk_lp_d = LP01;
    end else if (state_d inside {[TX_CLK_LP00:TX_CLK_TRAIL]}) begin
      clk_lp_d = LP00;
    end
    if (state_d == TX_DAT_LP01) begin
      dat_lp_d = LP01;
    end else if (state_d inside {[TX_DAT_LP00:TX_DAT_TRAIL]}) begin
      dat_lp_d = LP00;
    end
    // Helper counts for checking only: cycles in state, cycles of clocking
    dur_d = (state_d != state_q) ? '0 : ((&dur_q) ? dur_q : dur_q + ONE_CNT);
    run_d = !tx_clk_run_o ? '0 : ((&run_q) ? run_q : run_q + ONE_CNT);
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q          <= TX_IDLE;
      dur_q            <= '0;
      run_q            <= '0;
      tx_clk_lp_o      <= LP11;
      tx_dat_lp_o      <= LP11;
      tx_clk_hs_oe_o   <= 1'b0;
      tx_clk_run_o     <= 1'b0;
      tx_dat_hs_oe_o   <= 1'b0;
      tx_dat_sync_o    <= 1'b0;
      tx_dat_payload_o <= 1'b0;
      tx_dat_trail_o   <= 1'b0;
      tx_busy_o        <= 1'b0;
    end else begin
      state_q          <= state_d;
      dur_q            <= dur_d;
      run_q            <= run_d;
      tx_clk_lp_o      <= clk_lp_d;
      tx_dat_lp_o      <= dat_lp_d;
      tx_clk_hs_oe_o   <= clk_oe_d;
      tx_clk_run_o     <= run_en_d;
      tx_dat_hs_oe_o   <= dat_oe_d;
      tx_dat_sync_o    <= sync_d;
      tx_dat_payload_o <= pay_d;
      tx_dat_trail_o   <= trail_d;
      tx_busy_o        <= (state_d != TX_IDLE);
    end
  end

  // ****************************************************************
  // Receive settle windows on the calibration clock
  // ****************************************************************
  logic [N_RX_LANES-1:0]  rx_en;
  logic [1:0]             lane_lp [N_RX_LANES];
  logic [SET_W-1:0]       lane_ns [N_RX_LANES];

  assign lane_lp[0] = rx_clk_lp_i;
  assign lane_lp[1] = rx_dat_lp_i;
  assign lane_ns[0] = rx_clk_settle_ns_i;
  assign lane_ns[1] = rx_hs_settle_ns_i;

  for (genvar g = 0; g < N_RX_LANES; g++) begin : g_rx
    dlms_rx_e         st_q;
    dlms_rx_e         st_d;
    logic [1:0]       lp_m_q;
    logic [1:0]       lp_s_q;
    logic [SET_W-1:0] ns_m_q;
    logic [SET_W-1:0] ns_s_q;
    logic [SET_W-1:0] ns_c;
    logic [TMR_W-1:0] settle_cyc;
    logic [TMR_W-1:0] sc_q;
    logic [TMR_W-1:0] sc_d;
    logic             en_q;

    dlms_tmr_if rx_tmr ();

    dlms_timer u_rx_tmr (
      .clk_i   (clk_cal_i),
      .rst_n_i (rst_cal_n),
      .tmr     (rx_tmr)
    );

    // Pins and quasi-static settings both pass two flops first
    always_ff @(posedge clk_cal_i or negedge rst_cal_n) begin
      if (!rst_cal_n) begin
        lp_m_q <= LP11;
        lp_s_q <= LP11;
        ns_m_q <= SETTLE_MIN_NS;
        ns_s_q <= SETTLE_MIN_NS;
      end else begin
        lp_m_q <= lane_lp[g];
        lp_s_q <= lp_m_q;
        ns_m_q <= lane_ns[g];
        ns_s_q <= ns_m_q;
      end
    end

    // Clamp the setting into range, then round up to calibration cycles
    always_comb begin
      ns_c = ns_s_q;
      if (ns_s_q < SETTLE_MIN_NS) ns_c = SETTLE_MIN_NS;
      if (ns_s_q > SETTLE_MAX_NS) ns_c = SETTLE_MAX_NS;
      settle_cyc = TMR_W'((32'(ns_c) * PS_PER_NS + CAL_PERIOD_PS - 1) / CAL_PERIOD_PS);
    end

    // High-speed enable stays off until the settle counter expires
    always_comb begin
      st_d = st_q;
      unique case (st_q)
        RX_STOP:   if (lp_s_q == LP01) st_d = RX_REQ;
        RX_REQ:    if (lp_s_q == LP00) st_d = RX_SETTLE;
                   else if (lp_s_q == LP11) st_d = RX_STOP;
        RX_SETTLE: if (lp_s_q == LP11) st_d = RX_STOP;
                   else if (rx_tmr.done) st_d = RX_HS;
        RX_HS:     if (lp_s_q == LP11) st_d = RX_STOP;
      endcase
      rx_tmr.load  = (st_d == RX_SETTLE) && (st_q != RX_SETTLE);
      rx_tmr.value = settle_cyc;
      sc_d = (st_d != RX_SETTLE || st_q != RX_SETTLE) ? '0 : sc_q + ONE_CNT;
    end

    always_ff @(posedge clk_cal_i or negedge rst_cal_n) begin
      if (!rst_cal_n) begin
        st_q <= RX_STOP;
        sc_q <= '0;
        en_q <= 1'b0;
      end else begin
        st_q <= st_d;
        sc_q <= sc_d;
        en_q <= (st_d == RX_HS);
      end
    end

    assign rx_en[g] = en_q;

    property p_rx_settle;
      @(posedge clk_cal_i) disable iff (!rst_cal_n)
      (st_q == RX_SETTLE) ##1 (st_q == RX_HS) |-> $past(sc_q) == settle_cyc - ONE_CNT;
    endproperty
    a_rx_settle: assert property (p_rx_settle) else $error("settle window length wrong");
    property p_rx_mute;
      @(posedge clk_cal_i) disable iff (!rst_cal_n)
      (st_q != RX_HS) |-> !en_q;
    endproperty
    a_rx_mute: assert property (p_rx_mute) else $error("HS enabled inside settle");
  end : g_rx

  assign rx_clk_hs_en_o = rx_en[0];
  assign rx_dat_hs_en_o = rx_en[1];

  // Burst indication crosses to the system clock as a level
  logic burst_m_q;
  logic burst_s_q;

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      burst_m_q <= 1'b0;
      burst_s_q <= 1'b0;
    end else begin
      burst_m_q <= rx_en[1];
      burst_s_q <= burst_m_q;
    end
  end

  assign rx_burst_o = burst_s_q;

  // ****************************************************************
  // Transmit checks
  // ****************************************************************
  sequence s_clk_lp01_walk;
    (tx_clk_lp_o == LP01) [*7] ##1 (tx_clk_lp_o == LP00);
  endsequence
  sequence s_dat_lp01_walk;
    (tx_dat_lp_o == LP01) [*7] ##1 (tx_dat_lp_o == LP00);
  endsequence

  property p_clk_order;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (tx_clk_lp_o == LP11) ##1 (tx_clk_lp_o == LP01) |-> s_clk_lp01_walk;
  endproperty
  a_clk_order: assert property (p_clk_order) else $error("clock lane entry order");
  property p_dat_order;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (tx_dat_lp_o == LP11) ##1 (tx_dat_lp_o == LP01) |-> s_dat_lp01_walk;
  endproperty
  a_dat_order: assert property (p_dat_order) else $error("data lane entry order");
  property p_hs_exit;
    @(posedge clk_sys_i) disable iff (!rst_n)
    $fell(tx_clk_hs_oe_o) |-> (tx_clk_lp_o == LP11) && (tx_dat_lp_o == LP11);
  endproperty
  a_hs_exit: assert property (p_hs_exit) else $error("HS exit not to stop");
  property p_clk_pre;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (tx_dat_lp_o == LP01) && ($past(tx_dat_lp_o) == LP11) |-> run_q >= CLK_PRE_CNT;
  endproperty
  a_clk_pre: assert property (p_clk_pre) else $error("clock pre too short");
  property p_dwell(dlms_tx_e s, logic [TMR_W-1:0] n);
    @(posedge clk_sys_i) disable iff (!rst_n)
    (state_q == s) && (state_d != s) |-> dur_q == n - ONE_CNT;
  endproperty
  a_clk_prep: assert property (p_dwell(TX_CLK_LP00, CLK_PREP_CNT))
    else $error("clock prepare length");
  a_clk_trail: assert property (p_dwell(TX_CLK_TRAIL, CLK_TRAIL_CNT))
    else $error("clock trail length");
  a_clk_zero: assert property (p_dwell(TX_CLK_ZERO, CLK_ZERO_CNT))
    else $error("clock zero length");
  a_hs_prep: assert property (p_dwell(TX_DAT_LP00, HS_PREP_CNT))
    else $error("data prepare length");
  a_hs_trail: assert property (p_dwell(TX_DAT_TRAIL, HS_TRAIL_CNT))
    else $error("data trail length");
  a_lpx: assert property (p_dwell(TX_CLK_LP01, LPX_CNT))
    else $error("low-power period too short");
  a_hs_zero: assert property (p_dwell(TX_DAT_ZERO, HS_ZERO_CNT))
    else $error("data zero length");
  property p_clk_post;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (state_q == TX_CLK_TRAIL) && ($past(state_q) != TX_CLK_TRAIL)
      |-> $past(state_q) == TX_CLK_POST && $past(tx_clk_run_o);
  endproperty
  a_clk_post: assert property (p_clk_post) else $error("clock stopped before post");
endmodule : dlms_seq

// ### shared/dlms_pkg.sv
// Constants, timing counts and state types for the lane mode sequencer
package dlms_pkg;

  // ****************************************************************
  // Clock rates and widths
  // ****************************************************************
  localparam int SYS_PERIOD_PS = 8000;   // System clock, 125 MHz
  localparam int CAL_PERIOD_PS = 10000;  // Calibration clock, nominal 100 MHz
  localparam int UI_PS         = 1000;   // High-speed bit time, plain default
  localparam int TRAIL_N       = 1;      // Factor n of the data trail figure
  localparam int PS_PER_NS     = 1000;
  localparam int TMR_W         = 16;
  localparam int SET_W         = 12;
  localparam int N_RX_LANES    = 2;      // Lane 0 clock, lane 1 data

  // Least time to whole cycles, never below one cycle
  function automatic int ceil_cyc(input int ps, input int per);
    int c;
    c = (ps + per - 1) / per;
    return (c < 1) ? 1 : c;
  endfunction : ceil_cyc

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : max2

  // ****************************************************************
  // Transmit intervals, figures in their own units
  // ****************************************************************
  localparam int LPX_NS           = 50;
  localparam int CLK_PREP_NS      = 38;   // Least prepare, max is 95 ns
  localparam int CLK_PREP_MAX_NS  = 95;
  localparam int CLK_PZ_NS        = 300;  // Prepare plus zero
  localparam int CLK_PRE_UI       = 8;
  localparam int CLK_TRAIL_NS     = 60;
  localparam int CLK_POST_NS      = 60;   // No figure given, plain default
  localparam int HS_PREP_NS       = 40;
  localparam int HS_PREP_UI       = 4;
  localparam int HS_PZ_NS         = 145;
  localparam int HS_PZ_UI         = 10;
  localparam int HS_TRAIL_UI_A    = 8;
  localparam int HS_TRAIL_NS      = 60;
  localparam int HS_TRAIL_UI_B    = 4;

  localparam int CLK_PREP_C = ceil_cyc(CLK_PREP_NS * PS_PER_NS, SYS_PERIOD_PS);
  localparam int CLK_PZ_C   = ceil_cyc(CLK_PZ_NS * PS_PER_NS, SYS_PERIOD_PS);
  localparam int HS_PREP_C  = ceil_cyc(HS_PREP_NS * PS_PER_NS + HS_PREP_UI * UI_PS,
                                       SYS_PERIOD_PS);
  localparam int HS_PZ_C    = ceil_cyc(HS_PZ_NS * PS_PER_NS + HS_PZ_UI * UI_PS,
                                       SYS_PERIOD_PS);
  localparam int HS_TRAIL_PS = max2(TRAIL_N * HS_TRAIL_UI_A * UI_PS,
                                    HS_TRAIL_NS * PS_PER_NS + TRAIL_N * HS_TRAIL_UI_B * UI_PS);

  // ****************************************************************
  // Cycle counts loaded into the interval timer
  // ****************************************************************
  localparam logic [TMR_W-1:0] ONE_CNT      = 16'h0001;
  localparam logic [TMR_W-1:0] LPX_CNT      =
    TMR_W'(ceil_cyc(LPX_NS * PS_PER_NS, SYS_PERIOD_PS));
  localparam logic [TMR_W-1:0] CLK_PREP_CNT = TMR_W'(CLK_PREP_C);
  localparam logic [TMR_W-1:0] CLK_ZERO_CNT = TMR_W'(max2(CLK_PZ_C - CLK_PREP_C, 1));
  localparam logic [TMR_W-1:0] CLK_PRE_CNT  =
    TMR_W'(ceil_cyc(CLK_PRE_UI * UI_PS, SYS_PERIOD_PS));
  localparam logic [TMR_W-1:0] CLK_TRAIL_CNT =
    TMR_W'(ceil_cyc(CLK_TRAIL_NS * PS_PER_NS, SYS_PERIOD_PS));
  localparam logic [TMR_W-1:0] CLK_POST_CNT =
    TMR_W'(ceil_cyc(CLK_POST_NS * PS_PER_NS, SYS_PERIOD_PS));
  localparam logic [TMR_W-1:0] HS_PREP_CNT  = TMR_W'(HS_PREP_C);
  localparam logic [TMR_W-1:0] HS_ZERO_CNT  = TMR_W'(max2(HS_PZ_C - HS_PREP_C, 1));
  localparam logic [TMR_W-1:0] HS_TRAIL_CNT = TMR_W'(ceil_cyc(HS_TRAIL_PS, SYS_PERIOD_PS));

  // ****************************************************************
  // Receive settle range and line states {dp, dn}
  // ****************************************************************
  localparam logic [SET_W-1:0] SETTLE_MIN_NS = 12'h028;  // 40 ns
  localparam logic [SET_W-1:0] SETTLE_MAX_NS = 12'hA1E;  // 2590 ns
  localparam logic [1:0] LP11 = 2'h3;
  localparam logic [1:0] LP01 = 2'h1;
  localparam logic [1:0] LP00 = 2'h0;
  localparam logic [1:0] RST_SYNC_INIT = 2'h0;

  typedef enum logic [3:0] {
    TX_IDLE, TX_CLK_LP01, TX_CLK_LP00, TX_CLK_ZERO, TX_CLK_PRE,
    TX_DAT_LP01, TX_DAT_LP00, TX_DAT_ZERO, TX_DAT_SYNC, TX_DAT_PAYLOAD,
    TX_DAT_TRAIL, TX_CLK_POST, TX_CLK_TRAIL, TX_CLK_STOP
  } dlms_tx_e;

  typedef enum logic [1:0] {RX_STOP, RX_REQ, RX_SETTLE, RX_HS} dlms_rx_e;

endpackage : dlms_pkg

// ### shared/dlms_tmr_if.sv
// Interval timer control carrier between sequencer and timer
`timescale 1ns/10ps
interface dlms_tmr_if;
  logic                       load;
  logic [dlms_pkg::TMR_W-1:0] value;
  logic                       done;
  modport ctl (output load, output value, input done);
  modport tmr (input load, input value, output done);
endinterface : dlms_tmr_if

// ### design/dlms_timer.sv
// Programmable down counter that times one line-state interval
`timescale 1ns/10ps
module dlms_timer
  import dlms_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  dlms_tmr_if.tmr   tmr
);
  logic [TMR_W-1:0] cnt_q;
  logic [TMR_W-1:0] cnt_d;

  // Load value minus one so an interval of N lasts exactly N cycles
  always_comb begin
    cnt_d = cnt_q;
    if (tmr.load) begin
      cnt_d = tmr.value - ONE_CNT;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - ONE_CNT;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Done follows the count alone; masking it with load would loop through
  // the sequencer's next-state logic, which raises load from done
  assign tmr.done = (cnt_q == '0);
endmodule : dlms_timer

// ### verif/dlms_far_end.sv
// Far-end lane model: low-power entry walk, high-speed hold, then stop
`timescale 1ns/10ps
module dlms_far_end (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [9:0] hs_len_i,
  output logic [1:0]      lp_o
);
  int n = 0;
  initial lp_o = 2'h3;
  // Walk on the link clock; lines rest in stop between bursts
  always @(negedge clk_i) begin
    if (n == 0) begin
      lp_o <= 2'h3;
      if (go_i === 1'b1) n <= 1;
    end else begin
      n <= (n > 8 + hs_len_i) ? 0 : n + 1;
      // Four link cycles of LP-01 keep the 50 ns floor
      lp_o <= (n <= 4) ? 2'h1 : (n <= 8 + hs_len_i) ? 2'h0 : 2'h3;
    end
  end
endmodule : dlms_far_end

// ### verif/dlms_seq_tb.sv
// Self-checking bench for the lane mode sequencer
`timescale 1ns/10ps
module dlms_seq_tb;
  import dlms_pkg::*;
  logic             clk_sys_i = 1'b0, clk_cal_i = 1'b0, nrst_i = 1'b0, tx_req = 1'b0, go = 1'b0;
  logic [SET_W-1:0] settle = 12'h028;
  logic [9:0]       hs_len = 10'h000;
  logic [1:0]       c_lp, d_lp, rc_lp, rd_lp;
  logic             c_oe, run, d_oe, sync, pay, trail, busy, rc_en, rd_en, burst;
  int               n_fail = 0, n_compared = 0, pay_n = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  always #7.5 clk_cal_i = ~clk_cal_i;
  dlms_seq u_dlms_seq (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .clk_cal_i(clk_cal_i),
    .tx_req_i(tx_req), .tx_clk_lp_o(c_lp), .tx_clk_hs_oe_o(c_oe), .tx_clk_run_o(run),
    .tx_dat_lp_o(d_lp), .tx_dat_hs_oe_o(d_oe), .tx_dat_sync_o(sync), .tx_dat_payload_o(pay),
    .tx_dat_trail_o(trail), .tx_busy_o(busy), .rx_clk_lp_i(rc_lp), .rx_dat_lp_i(rd_lp),
    .rx_clk_settle_ns_i(settle), .rx_hs_settle_ns_i(settle), .rx_clk_hs_en_o(rc_en),
    .rx_dat_hs_en_o(rd_en), .rx_burst_o(burst));
  dlms_far_end u_dlms_far_end (.clk_i(clk_cal_i), .go_i(go), .hs_len_i(hs_len), .lp_o(rc_lp));
  dlms_far_end u_dlms_far_end_dat (.clk_i(clk_cal_i), .go_i(go), .hs_len_i(hs_len),
    .lp_o(rd_lp));
  // Ten payload cycles, then the request drops to close the burst
  always @(negedge clk_sys_i) if (pay === 1'b1 && ++pay_n >= 10) tx_req <= 1'b0;
  task automatic end_of_test;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  task automatic chk_cnt(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("Error at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_cnt
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: level %b, expected %b", $time, got, exp);
    end
  endtask : chk_bit
  // Line-state views of the transmit outputs
  function automatic bit obs(input int s);
    case (s)
      0: return c_lp === LP01;
      1: return c_lp === LP00 && c_oe === 1'b0;
      2: return c_oe === 1'b1 && run === 1'b0;
      3: return run === 1'b1 && d_lp === LP11;
      4: return d_lp === LP01;
      5: return d_lp === LP00 && d_oe === 1'b0;
      6: return d_oe === 1'b1 && sync === 1'b0 && pay === 1'b0 && trail === 1'b0;
      7: return sync === 1'b1;
      8: return pay === 1'b1;
      9: return trail === 1'b1;
      default: return c_lp === LP11 && busy === 1'b1;
    endcase
  endfunction : obs
  // Bounded wait for a state, then its length in system cycles
  task automatic hold(input int s, input int lo, input int hi, output int n);
    int w;
    n = 0;
    w = 0;
    while (!obs(s) && w < 400) begin
      @(negedge clk_sys_i);
      w++;
    end
    while (obs(s) && n < 400) begin
      @(negedge clk_sys_i);
      n++;
    end
    chk_cnt(n, lo, hi);
  endtask : hold
  // ********************************************************
  // Scenarios (transmit bounds in 8 ns cycles, receive bounds in calibration cycles, UI of 1 ns)
  // ********************************************************
  task automatic tx_burst;
    int a, b, c, d;
    tx_req <= 1'b1;
    hold(0, 7, 999, a);
    hold(1, 5, 11, a);
    hold(2, 1, 999, b);
    chk_cnt(a + b, 38, 999);
    hold(3, 1, 999, c);
    hold(4, 7, 999, c);
    hold(5, 6, 11, c);
    hold(6, 1, 999, d);
    chk_cnt(c + d, 20, 999);
    hold(7, 1, 1, d);
    hold(8, 10, 999, d);
    hold(9, 8, 999, d);
    hold(3, 1, 999, d);
    hold(2, 8, 999, d);
    hold(10, 7, 999, d);
    chk_bit(busy, 1'b0);
    $display("tx burst test done");
  endtask : tx_burst
  // Settle from far-end LP-00; cyc of 0 means a burst cut short
  task automatic rx_case(input logic [SET_W-1:0] ns, input int cyc, input logic [9:0] len);
    int n;
    bit seen;
    @(negedge clk_sys_i);
    settle <= ns;
    hs_len <= len;
    go <= 1'b1;
    n = 0;
    seen = 0;
    while (rc_lp !== LP00 && n < 20) begin
      @(posedge clk_cal_i);
      n++;
    end
    go <= 1'b0;
    n = 0;
    if (cyc > 0) begin
      while (rc_en !== 1'b1 && n < 400) begin
        @(negedge clk_cal_i);
        n++;
      end
      chk_cnt(n, cyc + 2, cyc + 4);
      #1 chk_bit(rd_en, 1'b1);
      repeat (4) @(negedge clk_sys_i);
      chk_bit(burst, 1'b1);
    end
    n = 0;
    while (rc_lp !== LP11 && n < 400) begin
      @(posedge clk_cal_i);
      seen |= (cyc == 0 && rc_en === 1'b1);
      n++;
    end
    repeat (6) @(posedge clk_cal_i);
    chk_bit(seen, 1'b0);
    chk_bit(rc_en, 1'b0);
    $display("rx settle test done");
  endtask : rx_case
  initial begin
    repeat (6) @(negedge clk_sys_i);
    nrst_i <= 1'b1;
    repeat (4) @(negedge clk_sys_i);
    chk_bit(c_lp === LP11, 1'b1);
    tx_burst();
    rx_case(12'h014, 4, 10'h12C);
    rx_case(12'h12C, 30, 10'h12C);
    rx_case(12'hFA0, 259, 10'h12C);
    rx_case(12'h12C, 0, 10'h00A);
    end_of_test();
  end
  // Watchdog well past the expected run length
  initial begin
    #100000;
    n_fail++;
    end_of_test();
  end
endmodule : dlms_seq_tb
